// file: aesc_defines.vh
// Shared constants of the block cipher engine: map, fields, timing
`ifndef AESC_DEFINES_VH
`define AESC_DEFINES_VH
`define AESC_ADDR_W 8
`define AESC_OFS_CTRL 8'h00
`define AESC_OFS_STATUS 8'h04
`define AESC_OFS_STATE0 8'h10
`define AESC_OFS_STATE3 8'h1C
`define AESC_OFS_KEY0 8'h20
`define AESC_OFS_KEY3 8'h2C
`define AESC_CTRL_START 0
`define AESC_CTRL_DECRYPT 1
`define AESC_CTRL_XORLOAD 2
`define AESC_CTRL_AUTO 3
`define AESC_CTRL_IRQEN 4
`define AESC_CTRL_W 5
`define AESC_ST_BUSY 0
`define AESC_ST_DONE 1
`define AESC_RUN_CYCLES 9'd375
`define AESC_CYC_W 9
`define AESC_ROUNDS 4'hA
`define AESC_RCON_FIRST 8'h01
`define AESC_GF_POLY 8'h1B
`define AESC_AFF_FWD 8'h63
`define AESC_AFF_INV 8'h05
`define AESC_ZERO32 32'h0000_0000
`define AESC_FULL_MASK 16'hFFFF
`endif

// file: aesc_sbox.v
// Byte substitution, forward or inverse, computed from the field inverse
`timescale 1ns/1ns
`include "aesc_defines.vh"
module aesc_sbox (
  input wire inv,
  input wire [7:0] din,
  output wire [7:0] dout
);
  // Field multiply modulo the cipher polynomial
  function [7:0] gmul;
    input [7:0] a;
    input [7:0] b;
    reg [7:0] p;
    reg [7:0] x;
    integer i;
    begin
      p = 8'h00;
      x = a;
      for (i = 0; i < 8; i = i + 1)
      begin
        if (b[i])
          p = p ^ x;
        x = {x[6:0], 1'b0} ^ (x[7] ? `AESC_GF_POLY : 8'h00);
      end
      gmul = p;
    end
  endfunction

  // Inverse as x^254; zero maps to zero as the cipher needs
  function [7:0] ginv;
    input [7:0] a;
    reg [7:0] p;
    reg [7:0] acc;
    integer i;
    begin
      p = a;
      acc = 8'h01;
      for (i = 1; i < 8; i = i + 1)
      begin
        p = gmul(p, p);
        acc = gmul(acc, p);
      end
      ginv = acc;
    end
  endfunction

  // Rotate left by n bits
  function [7:0] rotl;
    input [7:0] a;
    input integer n;
    begin
      rotl = (a << n) | (a >> (8 - n));
    end
  endfunction

  wire [7:0] aff_in; // Inverse affine applied before the field inverse
  wire [7:0] inv_out; // Field inverse of the selected operand
  wire [7:0] aff_fwd; // Forward affine after the field inverse

  assign aff_in = rotl(din, 1) ^ rotl(din, 3) ^ rotl(din, 6) ^ `AESC_AFF_INV;
  assign inv_out = ginv(inv ? aff_in : din);
  assign aff_fwd = inv_out ^ rotl(inv_out, 1) ^ rotl(inv_out, 2) ^ rotl(inv_out, 3)
    ^ rotl(inv_out, 4) ^ `AESC_AFF_FWD;
  assign dout = inv ? inv_out : aff_fwd;
endmodule // aesc_sbox

// file: aesc_mixcol.v
// Column mixing of one 4-byte column, forward or inverse
`timescale 1ns/1ns
`include "aesc_defines.vh"
module aesc_mixcol (
  input wire inv,
  input wire [31:0] din,
  output wire [31:0] dout
);
  // Multiply by two in the field
  function [7:0] xt;
    input [7:0] a;
    begin
      xt = {a[6:0], 1'b0} ^ (a[7] ? `AESC_GF_POLY : 8'h00);
    end
  endfunction

  wire [7:0] a0 = din[7:0];
  wire [7:0] a1 = din[15:8];
  wire [7:0] a2 = din[23:16];
  wire [7:0] a3 = din[31:24];
  // Inverse mixing is a premultiply followed by the forward matrix
  wire [7:0] u = inv ? xt(xt(a0 ^ a2)) : 8'h00;
  wire [7:0] v = inv ? xt(xt(a1 ^ a3)) : 8'h00;
  wire [7:0] b0 = a0 ^ u;
  wire [7:0] b1 = a1 ^ v;
  wire [7:0] b2 = a2 ^ u;
  wire [7:0] b3 = a3 ^ v;

  assign dout[7:0] = xt(b0) ^ xt(b1) ^ b1 ^ b2 ^ b3;
  assign dout[15:8] = b0 ^ xt(b1) ^ xt(b2) ^ b2 ^ b3;
  assign dout[23:16] = b0 ^ b1 ^ xt(b2) ^ xt(b3) ^ b3;
  assign dout[31:24] = xt(b0) ^ b0 ^ b1 ^ b2 ^ xt(b3);
endmodule // aesc_mixcol

// file: aesc_top.v
// Block cipher engine top: APB registers, key and state memory, round engine
//
// What this block does
// - Encrypt or decrypt one 128-bit block, 128-bit key.
// - Finish 375 cycles after start, then flag done.
// - Result readable from state; optional interrupt.
// - Pulse DMA trigger when an operation completes.
// - Auto-start once all state bytes written.
// - XOR load mode combines writes into state.
`timescale 1ns/1ns
`include "aesc_defines.vh"
module aesc_top (
  input wire SYS_CLK,
  input wire RESETN,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [`AESC_ADDR_W-1:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [3:0] PSTRB,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  output reg IRQ,
  output reg DMA_TRIG,
  output reg BUSY
);
  // Engine states, one-hot
  localparam S_IDLE = 4'b0001;
  localparam S_KEYX = 4'b0010;
  localparam S_RND = 4'b0100;
  localparam S_WAIT = 4'b1000;

  reg [3:0] fsm_reg; // Engine state
  reg [3:0] fsm_next;
  reg [`AESC_CYC_W-1:0] cyc_reg; // Cycles since start
  reg [3:0] rnd_reg; // Round or key step counter
  reg [127:0] st_reg; // State memory, doubles as working state
  reg [127:0] key_reg; // Key memory as written by software
  reg [127:0] wk_reg; // Working round key
  reg [7:0] rcon_reg; // Round constant of the key schedule
  reg [`AESC_CTRL_W-1:0] ctrl_reg; // Mode bits; start bit reads zero
  reg done_reg; // Sticky completion flag
  reg run_dec_reg; // Direction latched at start
  reg [15:0] fill_reg; // State bytes written since last start

  // Bus decode; a write lands at the edge where PREADY is seen high
  wire access = PSEL & PENABLE;
  wire wr_go = access & PREADY & PWRITE;
  wire idle = fsm_reg == S_IDLE;
  wire hit_ctrl = PADDR == `AESC_OFS_CTRL;
  wire hit_stat = PADDR == `AESC_OFS_STATUS;
  wire hit_st = (PADDR >= `AESC_OFS_STATE0) && (PADDR <= `AESC_OFS_STATE3)
    && (PADDR[1:0] == 2'b00);
  wire hit_key = (PADDR >= `AESC_OFS_KEY0) && (PADDR <= `AESC_OFS_KEY3)
    && (PADDR[1:0] == 2'b00);
  wire mapped = hit_ctrl | hit_stat | hit_st | hit_key;
  wire [1:0] widx = PADDR[3:2];

  // Byte-lane write into state memory, replacing or XORing
  reg [127:0] st_wr;
  reg [15:0] fill_wr;
  integer b;
  always @*
  begin
    st_wr = st_reg;
    fill_wr = fill_reg;
    for (b = 0; b < 4; b = b + 1)
    begin
      if (PSTRB[b])
      begin
        if (ctrl_reg[`AESC_CTRL_XORLOAD])
          st_wr[{widx, 5'd0} + b * 8 +: 8] = st_reg[{widx, 5'd0} + b * 8 +: 8]
            ^ PWDATA[b * 8 +: 8];
        else
          st_wr[{widx, 5'd0} + b * 8 +: 8] = PWDATA[b * 8 +: 8];
        fill_wr[{widx, 2'd0} + b] = 1'b1;
      end
    end
  end

  // Byte-lane write into key memory
  reg [127:0] key_wr;
  integer k;
  always @*
  begin
    key_wr = key_reg;
    for (k = 0; k < 4; k = k + 1)
    begin
      if (PSTRB[k])
        key_wr[{widx, 5'd0} + k * 8 +: 8] = PWDATA[k * 8 +: 8];
    end
  end

  // Start requests; memory writes while running are dropped, so the result
  // cannot be corrupted half way through a run
  wire st_write = wr_go & hit_st & idle;
  wire sw_start = wr_go & hit_ctrl & PWDATA[`AESC_CTRL_START];
  wire auto_start = st_write & ctrl_reg[`AESC_CTRL_AUTO] & (fill_wr == `AESC_FULL_MASK);
  wire start = idle & (sw_start | auto_start);
  wire start_dec = hit_ctrl ? PWDATA[`AESC_CTRL_DECRYPT] : ctrl_reg[`AESC_CTRL_DECRYPT];
  wire finish = (fsm_reg != S_IDLE) && (cyc_reg == `AESC_RUN_CYCLES - 9'd1);
  // Done is cleared by software or by a new start; completion still wins
  wire done_clr = start | (wr_go & hit_stat & PWDATA[`AESC_ST_DONE]);

  // Key schedule step, forward or backward
  wire inv_key = (fsm_reg == S_RND) & run_dec_reg;
  wire [31:0] w0 = wk_reg[31:0];
  wire [31:0] w1 = wk_reg[63:32];
  wire [31:0] w2 = wk_reg[95:64];
  wire [31:0] w3 = wk_reg[127:96];
  wire [31:0] ks_src = inv_key ? (w3 ^ w2) : w3;
  wire [31:0] ks_rot = {ks_src[7:0], ks_src[31:8]};
  wire [31:0] ks_sub;
  wire [7:0] rcon_half = rcon_reg[0] ? (((rcon_reg ^ `AESC_GF_POLY) >> 1) | 8'h80)
    : (rcon_reg >> 1);
  wire [7:0] rcon_dbl = {rcon_reg[6:0], 1'b0} ^ (rcon_reg[7] ? `AESC_GF_POLY : 8'h00);
  wire [31:0] fw0 = w0 ^ ks_sub ^ {24'h000000, rcon_reg};
  wire [31:0] fw1 = w1 ^ fw0;
  wire [31:0] fw2 = w2 ^ fw1;
  wire [127:0] k_fwd = {w3 ^ fw2, fw2, fw1, fw0};
  wire [127:0] k_inv = {w3 ^ w2, w2 ^ w1, w1 ^ w0, w0 ^ ks_sub ^ {24'h000000, rcon_half}};
  wire [127:0] k_next = inv_key ? k_inv : k_fwd;

  // Row shift in either direction, then substitution
  wire [127:0] shifted;
  wire [127:0] subbed;
  wire [127:0] mix_in;
  wire [127:0] mixed;
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1)
    begin : g_byte
      assign shifted[g * 8 +: 8] = run_dec_reg
        ? st_reg[((g % 4) + 4 * (((g / 4) + 4 - (g % 4)) % 4)) * 8 +: 8]
        : st_reg[((g % 4) + 4 * (((g / 4) + (g % 4)) % 4)) * 8 +: 8];
      aesc_sbox u_sbox (
        .inv(run_dec_reg),
        .din(shifted[g * 8 +: 8]),
        .dout(subbed[g * 8 +: 8])
      );
    end
    for (g = 0; g < 4; g = g + 1)
    begin : g_col
      aesc_sbox u_ksbox (
        .inv(1'b0),
        .din(ks_rot[g * 8 +: 8]),
        .dout(ks_sub[g * 8 +: 8])
      );
      aesc_mixcol u_mix (
        .inv(run_dec_reg),
        .din(mix_in[g * 32 +: 32]),
        .dout(mixed[g * 32 +: 32])
      );
    end
  endgenerate

  // Encrypt mixes before the key add, decrypt after it
  wire last_rnd = rnd_reg == `AESC_ROUNDS - 4'd1;
  assign mix_in = run_dec_reg ? (subbed ^ k_next) : subbed;
  wire [127:0] rnd_out = last_rnd ? (subbed ^ k_next)
    : (run_dec_reg ? mixed : (mixed ^ k_next));

  // Engine sequencing
  always @*
  begin
    fsm_next = fsm_reg;
    case (fsm_reg)
      S_IDLE:
        if (start)
          fsm_next = start_dec ? S_KEYX : S_RND;
      S_KEYX:
        // Decrypt must first walk the schedule to the last round key
        if (last_rnd)
          fsm_next = S_RND;
      S_RND:
        if (last_rnd)
          fsm_next = S_WAIT;
      S_WAIT:
        // Pads the run out to the fixed latency software expects
        if (finish)
          fsm_next = S_IDLE;
      default:
        fsm_next = S_IDLE;
    endcase
  end

  // Engine registers, state and key memory
  always @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      fsm_reg <= S_IDLE;
      cyc_reg <= {`AESC_CYC_W{1'b0}};
      rnd_reg <= 4'h0;
      st_reg <= 128'h0;
      key_reg <= 128'h0;
      wk_reg <= 128'h0;
      rcon_reg <= `AESC_RCON_FIRST;
      run_dec_reg <= 1'b0;
      fill_reg <= 16'h0000;
    end
    else
    begin
      fsm_reg <= fsm_next;
      if (wr_go & hit_key & idle)
        key_reg <= key_wr;
      if (start)
      begin
        // Encrypt whitens at once; decrypt whitens after the key walk
        cyc_reg <= {`AESC_CYC_W{1'b0}};
        rnd_reg <= 4'h0;
        wk_reg <= key_reg;
        rcon_reg <= `AESC_RCON_FIRST;
        run_dec_reg <= start_dec;
        fill_reg <= 16'h0000;
        st_reg <= (st_write ? st_wr : st_reg) ^ (start_dec ? 128'h0 : key_reg);
      end
      else if (st_write)
      begin
        st_reg <= st_wr;
        fill_reg <= fill_wr;
      end
      if (!idle)
        cyc_reg <= cyc_reg + 9'd1;
      if (fsm_reg == S_KEYX)
      begin
        wk_reg <= k_fwd;
        rcon_reg <= rcon_dbl;
        rnd_reg <= last_rnd ? 4'h0 : rnd_reg + 4'd1;
        if (last_rnd)
          st_reg <= st_reg ^ k_fwd;
      end
      if (fsm_reg == S_RND)
      begin
        wk_reg <= k_next;
        rcon_reg <= run_dec_reg ? rcon_half : rcon_dbl;
        rnd_reg <= rnd_reg + 4'd1;
        st_reg <= rnd_out;
      end
    end
  end

  // Control, status and completion outputs
  always @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      ctrl_reg <= {`AESC_CTRL_W{1'b0}};
      done_reg <= 1'b0;
      IRQ <= 1'b0;
      DMA_TRIG <= 1'b0;
      BUSY <= 1'b0;
    end
    else
    begin
      // Mode bits take effect at once; start is a strobe and never stored
      if (wr_go & hit_ctrl)
        ctrl_reg <= PWDATA[`AESC_CTRL_W-1:0] & ~(5'h1 << `AESC_CTRL_START);
      // Completion wins over a clear in the same cycle
      if (finish)
        done_reg <= 1'b1;
      else if (done_clr)
        done_reg <= 1'b0;
      // Interrupt follows the next value of done, so a clear or a start drops it at once
      IRQ <= (finish | (done_reg & ~done_clr)) & ctrl_reg[`AESC_CTRL_IRQEN];
      DMA_TRIG <= finish;
      BUSY <= (fsm_next != S_IDLE);
    end
  end

  // APB answer: one wait state, read data captured at the same edge as PREADY rises
  always @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= `AESC_ZERO32;
    end
    else
    begin
      PREADY <= access & ~PREADY;
      PSLVERR <= access & ~PREADY & ~mapped;
      if (access & ~PREADY & ~PWRITE)
      begin
        if (hit_ctrl)
          PRDATA <= {27'h0, ctrl_reg};
        else if (hit_stat)
          PRDATA <= {30'h0, done_reg, ~idle};
        else if (hit_st)
          PRDATA <= st_reg[{widx, 5'd0} +: 32];
        else if (hit_key)
          PRDATA <= key_reg[{widx, 5'd0} +: 32];
        else
          // Unmapped reads return zero alongside the error flag
          PRDATA <= `AESC_ZERO32;
      end
    end
  end
endmodule // aesc_top

// file: aesc_checker.sv
// Port assertions for the block cipher engine
`timescale 1ns/1ns
`include "aesc_defines.vh"
module aesc_checker (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`AESC_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic IRQ,
  input wire logic DMA_TRIG,
  input wire logic BUSY
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  // Busy run length, counted so the long figure needs no repetition
  logic [9:0] run_reg;
  // Decoded map: control, status, four state and four key words
  wire mapped = PADDR[1:0] == 2'b00 && (PADDR < 8'h08 || (PADDR >= 8'h10 && PADDR < 8'h30));
  wire acc_end = PSEL && PENABLE && PREADY;
  wire rd_acc = PSEL && PENABLE && !PWRITE;
  wire go_wr = acc_end && PWRITE && PADDR == `AESC_OFS_CTRL && PWDATA[0] && PSTRB[0];
  // Counter clears whenever idle, so a late restart cannot inherit a count
  always @(posedge SYS_CLK)
    if (!RESETN || !BUSY)
      run_reg <= 10'h000;
    else
      run_reg <= run_reg + 10'h001;
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_answer;
    !PREADY ##1 PREADY;
  endsequence
  a_ready_wait: assert property (s_setup |=> s_answer) else $error("ready timing wrong");
  a_ready_once: assert property (PREADY |=> !PREADY) else $error("ready held");
  a_err_decode: assert property (acc_end |-> PSLVERR == !mapped) else $error("error flag wrong");
  a_err_zero: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0) else $error("error data");
  a_rdata_hold: assert property ($changed(PRDATA) |-> $past(rd_acc)) else $error("data moved");
  a_start_busy: assert property (go_wr && !BUSY |=> BUSY) else $error("no start");
  a_busy_len: assert property ($fell(BUSY) |-> run_reg == 10'd375)
    else $error("run length");
  a_trig_end: assert property (DMA_TRIG == $fell(BUSY))
    else $error("trigger misplaced");
  a_trig_once: assert property (DMA_TRIG |=> !DMA_TRIG) else $error("trigger held");
  a_irq_quiet: assert property (BUSY && $past(BUSY) |-> !IRQ) else $error("irq in run");
endmodule // aesc_checker
bind aesc_top aesc_checker aesc_checker_i (.SYS_CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PWDATA, .PSTRB, .PRDATA, .PREADY, .PSLVERR, .IRQ, .DMA_TRIG, .BUSY);

// file: aesc_apb_host.sv
// Bus master model standing in for the processor and the DMA side
`timescale 1ns/1ns
module aesc_apb_host (
  input wire logic clk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  // Idle bus at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end
  // One transfer; request held until ready is seen, then released
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [31:0] rd, output logic e);
  begin
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    // Wait as long as the slave needs; only the bench watchdog ends a hang
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released address and data lines show their inverse, not the last value
    paddr <= ~a;
    pwdata <= ~d;
  end
  endtask
endmodule // aesc_apb_host

// file: aesc_top_bench.sv
// Self-checking bench: register map, state loading, cipher runs
`timescale 1ns/1ns
`include "aesc_defines.vh"
module aesc_top_bench;
  logic sys_clk, resetn, psel, penable, pwrite, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  logic [3:0] pstrb;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, irq, dma_trig, busy;
  logic [7:0] sm [0:15]; // Model of the state bytes
  integer miscompares, tests_run, cyc, t0, i;
  // Reference block, little-endian words: plaintext, key, ciphertext
  logic [31:0] pt [0:3] = '{32'h33221100, 32'h77665544, 32'hBBAA9988, 32'hFFEEDDCC};
  logic [31:0] kw [0:3] = '{32'h03020100, 32'h07060504, 32'h0B0A0908, 32'h0F0E0D0C};
  logic [31:0] ct [0:3] = '{32'hD8E0C469, 32'h30047B6A, 32'h80B7CDD8, 32'h5AC5B470};
  aesc_top aesc_top_i (.SYS_CLK(sys_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .DMA_TRIG(dma_trig), .BUSY(busy));
  aesc_apb_host host_i (.clk(sys_clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb));
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Edge counter for run timing
  always @(posedge sys_clk) cyc <= cyc + 1;
  task conclude;
  begin
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    host_i.xfer(1'b1, a, d, s, rd, er);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
  begin
    host_i.xfer(1'b0, a, 32'h0, 4'h0, rd, er);
    chk(rd, e);
  end
  endtask
  function logic [31:0] smw(input integer k);
    smw = {sm[4*k+3], sm[4*k+2], sm[4*k+1], sm[4*k]};
  endfunction
  // State word write; the model follows strobes and the combine mode
  task st(input integer k, input logic [31:0] d, input logic [3:0] s, input logic x);
    integer b;
  begin
    wr(8'h10 + 8'(4*k), d, s);
    for (b = 0; b < 4; b++)
      if (s[b])
        sm[4*k+b] = x ? sm[4*k+b] ^ d[8*b+:8] : d[8*b+:8];
  end
  endtask
  // Completion pulse is seen one edge after the finishing edge
  task fin(input logic dec, input logic ie);
    integer k;
  begin
    while (dma_trig !== 1'b1 && cyc - t0 < 400) @(posedge sys_clk);
    chk(cyc - t0, 376);
    chk({31'h0, irq}, {31'h0, ie});
    for (k = 0; k < 16; k++)
      sm[k] = dec ? pt[k/4][8*(k%4)+:8] : ct[k/4][8*(k%4)+:8];
    for (k = 0; k < 4; k++)
      rdc(8'h10 + 8'(4*k), smw(k));
  end
  endtask
  initial
  begin
    #(40 * 8000);
    miscompares = miscompares + 1;
    conclude;
  end
  initial
  begin
    resetn = 1'b0;
    miscompares = 0;
    tests_run = 0;
    cyc = 0;
    void'($urandom(88));
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    rdc(`AESC_OFS_CTRL, 32'h0);
    rdc(`AESC_OFS_STATUS, 32'h0);
    rdc(8'h08, 32'h0);
    chk({31'h0, er}, 32'h1);
    wr(8'h34, 32'hFFFFFFFF, 4'hF);
    chk({31'h0, er}, 32'h1);
    // Random words with random byte strobes, plain then combining
    for (i = 0; i < 16; i++)
      sm[i] = 8'h00;
    for (i = 0; i < 12; i++)
      st(i % 4, $urandom, 4'($urandom), 1'b0);
    for (i = 0; i < 4; i++)
      rdc(8'h10 + 8'(4*i), smw(i));
    wr(`AESC_OFS_CTRL, 32'h4, 4'hF);
    for (i = 0; i < 8; i++)
      st(i % 4, $urandom, 4'($urandom), 1'b1);
    for (i = 0; i < 4; i++)
      rdc(8'h10 + 8'(4*i), smw(i));
    wr(`AESC_OFS_CTRL, 32'h0, 4'hF);
    for (i = 0; i < 4; i++)
    begin
      wr(8'h20 + 8'(4*i), kw[i], 4'hF);
      st(i, pt[i], 4'hF, 1'b0);
    end
    // Encrypt; a state write and a second start during the run are ignored
    wr(`AESC_OFS_CTRL, 32'h11, 4'hF);
    t0 = cyc;
    wr(8'h10, 32'h0, 4'hF);
    wr(`AESC_OFS_CTRL, 32'h11, 4'hF);
    rdc(`AESC_OFS_STATUS, 32'h1);
    fin(1'b0, 1'b1);
    rdc(`AESC_OFS_STATUS, 32'h2);
    wr(`AESC_OFS_STATUS, 32'h2, 4'hF);
    rdc(`AESC_OFS_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(`AESC_OFS_CTRL, 32'h13, 4'hF);
    t0 = cyc;
    fin(1'b1, 1'b1);
    // Auto-start decrypt: fourth state word launches the run
    wr(`AESC_OFS_CTRL, 32'hA, 4'hF);
    for (i = 0; i < 4; i++)
      st(i, ct[i], 4'hF, 1'b0);
    t0 = cyc;
    fin(1'b1, 1'b0);
    for (i = 0; i < 4; i++)
      rdc(8'h20 + 8'(4*i), kw[i]);
    conclude;
  end
endmodule // aesc_top_bench
